//--- hdl/serial_master_port.v
// Secondary serial master port with APB register access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "serial_master_map.vh"
module serial_master_port (
   input wire clk_sys, // System clock, 10 MHz
   input wire rst, // Synchronous reset, active high
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB direction, high for write
   input wire [7:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output wire pready, // APB ready
   output wire pslverr, // APB error on unmapped address
   output reg master_serial_clock, // Serial clock out
   output wire master_serial_clock_oe, // Serial clock drive enable
   output reg serial_out, // Serial data out
   output wire serial_out_oe, // Serial data drive enable
   input wire serial_in, // Serial data in from slaves
   output reg [4:0] chip_select_n, // Chip selects, active low
   output wire [4:0] chip_select_oe // Chip select drive enables
);

   // Sequencer states
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_LEAD = 2'd1;
   localparam [1:0] ST_SHIFT = 2'd2;
   localparam [1:0] ST_TRAIL = 2'd3;
   // Divider limits, cut to the counter width on purpose; all fit in 8 bits
   localparam integer H_32K_I = `HALF_32K;
   localparam integer H_128K_I = `HALF_128K;
   localparam integer H_512K_I = `HALF_512K;
   localparam integer H_1024K_I = `HALF_1024K;
   localparam integer H_2048K_I = `HALF_2048K;
   localparam integer H_4096K_I = `HALF_4096K;
   localparam [7:0] H_32K = H_32K_I[7:0];
   localparam [7:0] H_128K = H_128K_I[7:0];
   localparam [7:0] H_512K = H_512K_I[7:0];
   localparam [7:0] H_1024K = H_1024K_I[7:0];
   localparam [7:0] H_2048K = H_2048K_I[7:0];
   localparam [7:0] H_4096K = H_4096K_I[7:0];
   // Control reset value as a sized word so each field can be sliced
   localparam [23:0] CTRL_RST_W = `CTRL_RST;

   // Register decode: 0 unmapped, 1 control, 2 command, 3 data, 4 direction
   function [2:0] reg_sel;
      input [7:0] a;
      begin
         if (a == (`CTRL_IDX << 2)) reg_sel = 3'd1;
         else if (a == (`CMD_IDX << 2)) reg_sel = 3'd2;
         else if (a == (`DAT_IDX << 2)) reg_sel = 3'd3;
         else if (a == (`DIR_IDX << 2)) reg_sel = 3'd4;
         else reg_sel = 3'd0;
      end
   endfunction

   // Half serial period per rate code; reserved codes fall back to slowest
   function [7:0] half_lim;
      input [2:0] r;
      begin
         case (r)
            3'd0: half_lim = H_32K;
            3'd1: half_lim = H_128K;
            3'd2: half_lim = H_512K;
            3'd3: half_lim = H_1024K;
            3'd4: half_lim = H_2048K;
            3'd5: half_lim = H_4096K;
            default: half_lim = H_32K;
         endcase
      end
   endfunction

   // Control fields
   reg [4:0] cs_en_r;
   reg [2:0] byte_count_field_r;
   reg transfer_request_r;
   reg timeout_flag_r;
   reg clock_polarity_bit_r;
   reg request_collision_flag_r;
   reg clock_phase_bit_r;
   reg transfer_in_progress_r;
   reg [1:0] read_chan_r;
   reg [3:0] chan_en_r;
   reg [2:0] serial_clock_rate_select_r;
   reg wired_or_r;
   reg [15:0] command_word_register_r;
   reg [23:0] serial_master_data_word_r;
   reg read_dir_r;

   // Sequencer
   reg [1:0] state_r;
   reg [7:0] half_cnt_r;
   reg [7:0] lat_half_r;
   reg lat_cpha_r;
   reg lat_read_r;
   reg [6:0] edge_r;
   reg [6:0] last_edge_r;
   reg [5:0] sample_cnt_r;
   reg [39:0] tx_r;
   reg [23:0] rx_r;

   // Input synchroniser and filter
   reg in_s1_r;
   reg in_s2_r;
   reg in_s3_r;
   reg in_f_r;

   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable;
   wire [2:0] sel = reg_sel(paddr);
   wire wr_en = access_ph & pwrite;
   wire wr_ctrl = wr_en & (sel == 3'd1);
   wire start_req = wr_ctrl & pwdata[`REQ_BIT];
   wire start = start_req & ~transfer_in_progress_r;
   // One strobe per writable register keeps the write logic readable.
   // Writes land at the access edge only, so a setup cycle alone
   // never disturbs a register, whatever the address says.
   wire wr_cmd = wr_en & (sel == 3'd2);
   wire wr_dat = wr_en & (sel == 3'd3);
   wire wr_dir = wr_en & (sel == 3'd4);
   // Last tick of the trailing half period ends the frame
   wire frame_done = (state_r == ST_TRAIL) && tick;
   // Filtered input; a level the second and third flops agree on is used
   // at once, since a half period of one cycle at the fastest rate leaves no room for more delay
   wire in_ok = (in_s2_r == in_s3_r) ? in_s3_r : in_f_r;
   wire tick = (state_r != ST_IDLE) && (half_cnt_r == lat_half_r - 8'd1);
   wire sample_edge = (edge_r[0] == lat_cpha_r);

   wire [23:0] ctrl_word = {wired_or_r, serial_clock_rate_select_r, chan_en_r, read_chan_r,
      transfer_in_progress_r, clock_phase_bit_r, request_collision_flag_r,
      clock_polarity_bit_r, timeout_flag_r, transfer_request_r, byte_count_field_r, cs_en_r};

   // Byte count: one to five; reads never fewer than three
   wire [3:0] n_raw = {1'b0, byte_count_field_r} + 4'd1;
   wire [3:0] n_wr = (n_raw > 4'd5) ? 4'd5 : n_raw; // R5
   wire [3:0] n_bytes = (read_dir_r && n_wr < 4'd3) ? 4'd3 : n_wr; // R8
   wire [2:0] pad_bytes = 3'd5 - n_bytes[2:0];
   wire [23:0] data_aligned = serial_master_data_word_r << {pad_bytes, 3'b000};
   wire [39:0] tx_load = {command_word_register_r, data_aligned}; // R3 R6
   wire [6:0] n_edges = {n_bytes[2:0], 4'b0000};

   // Zero wait state; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access_ph & (sel == 3'd0);

   // Wired-or mode only drives low; push-pull drives always
   assign master_serial_clock_oe = ~wired_or_r | ~master_serial_clock;
   assign serial_out_oe = ~wired_or_r | ~serial_out;
   // Each select pin gets its own enable, same wired-or rule as the clock
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_cs_oe
         assign chip_select_oe[g] = ~wired_or_r | ~chip_select_n[g];
      end
   endgenerate

   // Read data captured in setup so it is stable through access
   always @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (setup_ph & ~pwrite) begin
         case (sel)
            3'd1: prdata <= {8'h00, ctrl_word};
            3'd2: prdata <= {16'h0000, command_word_register_r};
            3'd3: prdata <= {8'h00, serial_master_data_word_r}; // R1
            3'd4: prdata <= {31'h00000000, read_dir_r};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // Control register; request and busy are owned by the sequencer
   always @(posedge clk_sys) begin
      if (rst) begin
         wired_or_r <= CTRL_RST_W[`WOM_BIT];
         serial_clock_rate_select_r <= CTRL_RST_W[`RATE_MSB:`RATE_LSB];
         chan_en_r <= CTRL_RST_W[`EN_MSB:`EN_LSB];
         read_chan_r <= CTRL_RST_W[`RCH_MSB:`RCH_LSB];
         clock_phase_bit_r <= CTRL_RST_W[`CPHA_BIT];
         clock_polarity_bit_r <= CTRL_RST_W[`CPOL_BIT];
         timeout_flag_r <= CTRL_RST_W[`TM_BIT];
         byte_count_field_r <= CTRL_RST_W[`BYTE_COUNT_FIELD_MSB:`BYTE_COUNT_FIELD_LSB];
         cs_en_r <= CTRL_RST_W[`CS_MSB:`CS_LSB];
         request_collision_flag_r <= 1'b0;
         command_word_register_r <= `CMD_RST;
         read_dir_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            wired_or_r <= pwdata[`WOM_BIT];
            serial_clock_rate_select_r <= pwdata[`RATE_MSB:`RATE_LSB]; // R19
            chan_en_r <= pwdata[`EN_MSB:`EN_LSB];
            read_chan_r <= pwdata[`RCH_MSB:`RCH_LSB];
            clock_phase_bit_r <= pwdata[`CPHA_BIT]; // R10
            clock_polarity_bit_r <= pwdata[`CPOL_BIT]; // R10
            timeout_flag_r <= pwdata[`TM_BIT];
            byte_count_field_r <= pwdata[`BYTE_COUNT_FIELD_MSB:`BYTE_COUNT_FIELD_LSB];
            cs_en_r <= pwdata[`CS_MSB:`CS_LSB];
         end
         // Collision: a set in the same cycle beats the clear
         if (start_req & transfer_in_progress_r)
            request_collision_flag_r <= 1'b1; // R18
         else if (wr_ctrl & ~pwdata[`REQUEST_COLLISION_FLAG_BIT])
            request_collision_flag_r <= 1'b0; // R18
         if (wr_cmd)
            command_word_register_r <= pwdata[15:0];
         if (wr_dir)
            read_dir_r <= pwdata[`DIR_READ_BIT];
      end
   end

   // Input pin: three flops, change accepted once second and third agree
   always @(posedge clk_sys) begin
      if (rst) begin
         in_s1_r <= 1'b0;
         in_s2_r <= 1'b0;
         in_s3_r <= 1'b0;
         in_f_r <= 1'b0;
      end else begin
         in_s1_r <= serial_in;
         in_s2_r <= in_s1_r;
         in_s3_r <= in_s2_r;
         if (in_s2_r == in_s3_r)
            in_f_r <= in_s3_r;
      end
   end

   // Half-period divider, restarted at each launch
   always @(posedge clk_sys) begin
      if (rst) begin
         half_cnt_r <= 8'h00;
      end else if (start || tick || state_r == ST_IDLE) begin
         half_cnt_r <= 8'h00;
      end else begin
         half_cnt_r <= half_cnt_r + 8'd1;
      end
   end

   // Transfer sequencer.
   // Launch cycle: selects fall, clock sits at its polarity.
   // Lead: one half period with the select low and the clock still.
   // Shift: one clock edge per half period, sixteen edges per byte.
   // Trail: one more half period before the selects rise.
   // Rate, phase, count and direction are latched at launch, so a
   // register write in mid-frame cannot tear the frame; polarity is not,
   // and software must leave it alone while the port is busy.
   always @(posedge clk_sys) begin
      if (rst) begin
         state_r <= ST_IDLE;
         transfer_request_r <= 1'b0;
         transfer_in_progress_r <= 1'b0;
         lat_half_r <= 8'h01;
         lat_cpha_r <= 1'b0;
         lat_read_r <= 1'b0;
         edge_r <= 7'h00;
         last_edge_r <= 7'h00;
         sample_cnt_r <= 6'h00;
         tx_r <= 40'h0000000000;
         rx_r <= 24'h000000;
         serial_master_data_word_r <= `DAT_RST; // R1
         master_serial_clock <= 1'b0;
         serial_out <= 1'b0;
         chip_select_n <= 5'h1F;
      end else begin
         // Software write to data; a finishing read overrides below
         if (wr_dat)
            serial_master_data_word_r <= pwdata[23:0];
         case (state_r)
            ST_IDLE: begin
               master_serial_clock <= clock_polarity_bit_r; // R12 R13
               if (start) begin // R4
                  state_r <= ST_LEAD;
                  transfer_request_r <= 1'b1;
                  transfer_in_progress_r <= 1'b1; // R17
                  lat_half_r <= half_lim(serial_clock_rate_select_r); // R19
                  lat_cpha_r <= clock_phase_bit_r;
                  lat_read_r <= read_dir_r;
                  edge_r <= 7'h00;
                  last_edge_r <= n_edges - 7'd1; // R20
                  sample_cnt_r <= 6'h00;
                  rx_r <= 24'h000000;
                  chip_select_n <= ~cs_en_r; // R2 R21
                  // Phase 0 puts the first bit out with the select
                  if (!clock_phase_bit_r) begin
                     serial_out <= tx_load[39]; // R12
                     tx_r <= {tx_load[38:0], 1'b0};
                  end else begin
                     tx_r <= tx_load; // R13
                  end
               end
            end
            ST_LEAD: begin
               // Select settles half a period before the first edge
               if (tick)
                  state_r <= ST_SHIFT; // R21
            end
            ST_SHIFT: begin
               if (tick) begin
                  master_serial_clock <= ~master_serial_clock; // R2
                  edge_r <= edge_r + 7'd1;
                  if (sample_edge) begin // R11 R14
                     // Command bytes of a read are not stored
                     if (!lat_read_r || sample_cnt_r >= 6'd16) begin
                        rx_r <= {rx_r[22:0], in_ok}; // R7 R20
                     end
                     sample_cnt_r <= sample_cnt_r + 6'd1;
                  end else begin
                     serial_out <= tx_r[39]; // R11 R14 R20
                     tx_r <= {tx_r[38:0], 1'b0};
                  end
                  if (edge_r == last_edge_r)
                     state_r <= ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               // Hold select half a period past the final edge
               if (frame_done) begin
                  state_r <= ST_IDLE;
                  chip_select_n <= 5'h1F; // R21
                  transfer_request_r <= 1'b0; // R16
                  transfer_in_progress_r <= 1'b0; // R17
                  if (lat_read_r)
                     serial_master_data_word_r <= rx_r; // R7
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // serial_master_port

//--- hdl/serial_master_map.vh
// Register map, field positions, reset values and clock rates of the serial master port
// Operation
// R1: 24-bit data word register, resets to zero
// R2: Port is master only, drives clock and selects
// R3: Write command is opcode plus 8-bit address
// R4: Request bit write launches one transfer
// R5: Write sends count plus one bytes, one to five
// R6: Command and data bytes go out unmodified
// R7: Read bytes received land in data word
// R8: Read sends two command bytes, receives rest
// R9: Software keeps reads two out, 1-3 in
// R10: Polarity and phase bits pick four modes
// R11: Modes 0 and 3 sample rising edges
// R12: Mode 0 idles low, first bit before clock
// R13: Mode 3 idles high, data at first fall
// R14: Modes 1 and 2 sample falling edges
// R15: Slave drives input only while answering read
// R16: Request bit clears itself at transfer end
// R17: Busy flag set throughout a transfer
// R18: Request while busy sets sticky collision flag
// R19: Three-bit rate field picks clock frequency
// R20: Eight clocks per byte, MSB first
// R21: Chip select low across every byte
`ifndef SERIAL_MASTER_MAP_VH
`define SERIAL_MASTER_MAP_VH
// Register indices; byte address is four times the index
`define CTRL_IDX 8'h10
`define CMD_IDX 8'h11
`define DAT_IDX 8'h12
`define DIR_IDX 8'h13
// Reset values
`define CTRL_RST 24'h3000E0
`define CMD_RST 16'h0000
`define DAT_RST 24'h000000
// Control word field positions
`define CS_LSB 0
`define CS_MSB 4
`define BYTE_COUNT_FIELD_LSB 5
`define BYTE_COUNT_FIELD_MSB 7
`define REQ_BIT 8
`define TM_BIT 9
`define CPOL_BIT 10
`define REQUEST_COLLISION_FLAG_BIT 11
`define CPHA_BIT 12
`define BUSY_BIT 13
`define RCH_LSB 14
`define RCH_MSB 15
`define EN_LSB 16
`define EN_MSB 19
`define RATE_LSB 20
`define RATE_MSB 22
`define WOM_BIT 23
`define DIR_READ_BIT 0
// Standard opcodes
`define OP_WRITE 8'h02
`define OP_READ 8'h03
// System clock and serial clock rates in Hz
`define CLK_HZ 10000000
`define F_32K 32000
`define F_128K 128000
`define F_512K 512000
`define F_1024K 1024000
`define F_2048K 2048000
`define F_4096K 4096000
// Half serial clock periods in system cycles, rounded down
`define HALF_32K (`CLK_HZ / (2 * `F_32K))
`define HALF_128K (`CLK_HZ / (2 * `F_128K))
`define HALF_512K (`CLK_HZ / (2 * `F_512K))
`define HALF_1024K (`CLK_HZ / (2 * `F_1024K))
`define HALF_2048K (`CLK_HZ / (2 * `F_2048K))
`define HALF_4096K (`CLK_HZ / (2 * `F_4096K))
`endif

//--- sim/serial_master_port_assertions.sv
// Checker for the serial master port, bound to its top module
`timescale 1ns/1ps
module serial_master_port_assertions (
   input wire clk_sys, // Clock
   input wire rst, // Reset
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB write
   input wire [7:0] paddr, // APB address
   input wire [31:0] pwdata, // APB wdata
   input wire [31:0] prdata, // APB rdata
   input wire master_serial_clock, // Link clock
   input wire serial_out, // Link data out
   input wire [4:0] chip_select_n // Selects
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Bus decode; a launch is only seen from idle with some select enabled
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire idle = chip_select_n == 5'h1F;
   wire launch = wr && paddr == 8'h40 && pwdata[8] && pwdata[4:0] != 5'h00 && idle;
   AST_DATA_UPPER: assert property (acc && !pwrite && paddr == 8'h48 |-> prdata[31:24] == 8'h00)
      else $error("data word upper bits set");
   AST_LAUNCH_CS: assert property (launch |=> chip_select_n == ~$past(pwdata[4:0]))
      else $error("selects wrong after launch");
   AST_CS_HOLD: assert property (launch |=> (!idle) [*8])
      else $error("selects released early");
   AST_CS_STEADY: assert property (!idle && !$past(idle) |-> $stable(chip_select_n))
      else $error("selects moved mid transfer");
   AST_SCK_QUIET: assert property (idle && $past(idle) && !$past(wr) && !$past(wr, 2)
      |-> $stable(master_serial_clock))
      else $error("clock moved while idle");
   AST_SO_ON_EDGE: assert property (!idle && !$past(idle) && $changed(serial_out)
      |-> $changed(master_serial_clock))
      else $error("data changed away from a clock edge");
   AST_MASTER_ONLY: assert property ($changed(master_serial_clock) && !$past(wr)
      && !$past(wr, 2) |-> !idle)
      else $error("clock edge without a select");
   AST_SCK_START: assert property (launch && pwdata[22:20] == 3'h3
      |=> $stable(master_serial_clock) [*8] ##1 $changed(master_serial_clock))
      else $error("first clock edge mistimed");
   // Main scenarios
   COV_LAUNCH: cover property (launch);
   COV_MODE3: cover property (launch && pwdata[10] && pwdata[12]);
   COV_UNMAPPED: cover property (acc && paddr == 8'h50);
endmodule // serial_master_port_assertions
bind serial_master_port serial_master_port_assertions i_chk (.clk_sys, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .master_serial_clock, .serial_out, .chip_select_n);

//--- sim/spi_slave_model.sv
// Serial slave peripheral model: records the stream, answers read opcodes
`timescale 1ns/1ps
module spi_slave_model (
   input wire sck, // Link clock
   input wire cs_n, // Select, active low
   input wire mosi, // Data from port
   input wire cpol, // Mode polarity
   input wire cpha, // Mode phase
   input wire [23:0] reply, // Read answer
   output wire miso, // Data to port
   output reg [39:0] rx, // Bits seen, newest at bit 0
   output integer nbits // Bits in this frame
);
   reg [23:0] sh;
   reg cur, rd;
   // Rising in modes 0 and 3, falling in modes 1 and 2
   wire samp = sck ^ cpol ^ cpha;
   // New frame at select fall
   always @(negedge cs_n) begin
      nbits = 0;
      rd = 1'b0;
      sh = reply;
   end
   // MSB first; a read opcode turns the line after two bytes
   always @(posedge samp) begin
      if (!cs_n) begin
         rx = {rx[38:0], mosi};
         nbits = nbits + 1;
         if (nbits == 16) rd = rx[15:8] == 8'h03;
      end
   end
   // Answer bits on the launch edge
   always @(negedge samp) begin
      if (!cs_n && rd) begin
         cur = sh[23];
         sh = sh << 1;
      end
   end
   // Released line sits at the pull-up level
   assign miso = (!cs_n && rd) ? cur : 1'b1;
endmodule // spi_slave_model

//--- sim/tb.sv
// Self-checking bench for the serial master port
`timescale 1ns/1ps
module tb;
   reg clk_sys, rst, psel, penable, pwrite, link_cpol, link_cpha, err;
   reg [7:0] paddr;
   reg [31:0] pwdata, rd;
   reg [23:0] reply, dat;
   reg [15:0] cmd;
   reg [39:0] got;
   wire [31:0] prdata;
   wire pready, pslverr, sck, so, si, sck_oe, so_oe;
   wire [4:0] cs_oe;
   wire [4:0] cs_n;
   wire [39:0] rx;
   integer nbits, bad_count, compares, i, k;
   serial_master_port i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .master_serial_clock(sck), .master_serial_clock_oe(sck_oe),
      .serial_out(so), .serial_out_oe(so_oe), .serial_in(si), .chip_select_n(cs_n),
      .chip_select_oe(cs_oe));
   spi_slave_model i_slave (.sck, .cs_n(cs_n[0]), .mosi(so), .cpol(link_cpol),
      .cpha(link_cpha), .reply, .miso(si), .rx, .nbits);
   // 10 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Compare and count
   task check(input [39:0] g, input [39:0] e, input string msg);
      compares = compares + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, g, e);
      end
   endtask
   // Verdict, shared with every timeout
   task final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer; waits for pready under a bound
   task apb(input w, input [7:0] a, input [31:0] d);
      integer t;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge clk_sys);
         t = t + 1;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      err = pslverr;
      if (t >= 50) begin
         bad_count = bad_count + 1;
         final_report;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Load, launch and follow one transfer, then compare with the model
   task xfer(input [1:0] mode, input r, input [2:0] cnt, input coll);
      reg [31:0] ctl;
      integer n, t;
      n = cnt + 1;
      cmd = $urandom;
      if (r || mode != 2'd2) cmd[15:8] = r ? 8'h03 : 8'h02;
      dat = $urandom;
      reply <= $urandom;
      link_cpol <= mode[1];
      link_cpha <= mode[0];
      ctl = {9'h0, 3'h3, 7'h0, mode[0], 1'b0, mode[1], 2'b0, cnt, 5'h01};
      apb(1'b1, 8'h44, {16'h0000, cmd});
      apb(1'b1, 8'h48, {8'h00, dat});
      apb(1'b1, 8'h4C, {31'h0, r});
      apb(1'b1, 8'h40, ctl);
      apb(1'b1, 8'h40, ctl | 32'h100);
      apb(1'b0, 8'h40, 32'h0);
      check({rd[13], rd[11], rd[8]}, 3'b101, "busy");
      if (coll) apb(1'b1, 8'h40, ctl | 32'h100);
      t = 0;
      do begin
         apb(1'b0, 8'h40, 32'h0);
         t = t + 1;
      end while (rd[8] !== 1'b0 && t < 400);
      if (t >= 400) begin
         bad_count = bad_count + 1;
         final_report;
      end
      check({rd[13], rd[11]}, {1'b0, coll}, "done");
      check(nbits, 8 * n, "bits");
      got = r ? (rx >> (8 * n - 16)) & 40'hFFFF : rx & ((40'h1 << 8 * n) - 1);
      check(got, r ? cmd : {cmd, dat << 8 * (5 - n)} >> 8 * (5 - n), "sent");
      apb(1'b0, 8'h48, 32'h0);
      check(rd, r ? reply >> 8 * (5 - n) : dat, "data");
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = 0;
      {link_cpol, link_cpha, reply} = 0;
      bad_count = 0;
      compares = 0;
      k = $urandom(32'h7549826B);
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h003000E0, "ctrl reset");
      check({sck_oe, so_oe, cs_oe}, 7'h7F, "drive enables");
      apb(1'b0, 8'h48, 32'h0);
      check(rd, 32'h0, "data reset");
      apb(1'b1, 8'h48, 32'hFFFFFFFF);
      apb(1'b0, 8'h48, 32'h0);
      check(rd, 32'h00FFFFFF, "data rw");
      check(err, 1'b0, "mapped error");
      apb(1'b0, 8'h50, 32'h0);
      check({err, rd}, {1'b1, 32'h0}, "unmapped");
      $display("test registers done");
      // Every mode both ways, every legal count, some collisions
      for (i = 0; i < 16; i = i + 1) begin
         xfer(i[1:0], i[2], 3'(i[2] ? 2 + i % 3 : i % 5), i[3]);
         $display("test transfer %0d done", i);
      end
      final_report;
   end
endmodule // tb
